// *** apmc_power_ctrl.sv ***
`include "apmc_map.svh"

module apmc_power_ctrl
    import apmc_pkg::*;
#(
    parameter int SECTION_SETTLE_CYC = 16,                     // Settling time of one section.
    parameter int MIDRAIL_START_CYC  = `APMC_MIDRAIL_START_CYC // Midrail reference start-up.
)
(
    input  wire logic          clk,            // 40 MHz system clock.
    input  wire logic          arst_n,         // Asynchronous reset, active low.
    input  wire apmc_reg_req_s reg_req,        // Register access request.
    output logic [15:0]        reg_rdata,      // Read data.
    output logic               reg_rvalid,     // Read data valid pulse.
    input  wire apmc_vol_req_s vol_left,       // Left DAC volume and mute.
    input  wire apmc_vol_req_s vol_right,      // Right DAC volume and mute.
    input  wire logic          i2s_sync_err,   // Loss of I2S sync, foreign domain.
    output apmc_power_s        power_on,       // Section power enables.
    output logic               mono_source_select, // Mono output source.
    output logic               mic_bias_on,    // Microphone bias enable.
    output logic               xtal_osc_on,    // Crystal oscillator enable.
    output logic               clk_buf_on,     // Clock buffer enable.
    output logic               sync_monitor_on,// Sync monitor enable.
    output logic               bass_enable,    // Effects filter enable.
    output logic               deemph_enable,  // De-emphasis enable.
    output logic [6:0]         gain_left,      // Stepped left gain.
    output logic [6:0]         gain_right,     // Stepped right gain.
    output logic               dac_zero_left,  // Send zeroes to left filter.
    output logic               dac_zero_right  // Send zeroes to right filter.
);

    // ------------------------------------------------------------------
    // Constants and storage.
    // ------------------------------------------------------------------
    localparam int STEP_NORMAL_CYC = `APMC_STEP_NORMAL_CYC;
    localparam int STEP_HALF_CYC   = `APMC_STEP_HALF_CYC;
    localparam int SEQ_W           = $clog2(MIDRAIL_START_CYC + SECTION_SETTLE_CYC + 1);

    logic [7:0]       pd_bits_reg;
    logic             mic_bias_pd_reg;
    logic             xtal_en_reg;
    logic             clkbuf_en_reg;
    logic             sync_mon_pd_reg;
    logic             bass_reg;
    logic             deemph_reg;
    logic             mono_src_reg;
    logic             step_rate_reg;
    logic             step_done_reg;
    logic             pwr_done_reg;
    logic             sync_lost_reg;
    logic             midrail_hold_reg;
    logic [1:0]       sync_meta_reg;
    logic [10:0]      tick_cnt_reg;
    logic             tick;
    logic [SEQ_W-1:0] seq_cnt_reg;
    apmc_seq_e        seq_state_reg;
    logic             wr_power;
    logic [7:0]       pd_bits_next;
    apmc_power_s      power_now;
    apmc_power_s      power_next;
    logic [6:0]       target_left;
    logic [6:0]       target_right;

    // ------------------------------------------------------------------
    // Power decoding, shared by the outputs and the sequencer.
    // ------------------------------------------------------------------

    // Turns the power-down byte into section enables; the hold counts only while the reference bit is 0.
    function automatic apmc_power_s power_decode(input logic [7:0] pd, input logic hold);
        apmc_power_s p;
        logic        up;
        p  = '0;
        up = ~pd[`APMC_BIT_MASTER_PD-8];
        p.bypass_path   = up & ~pd[`APMC_BIT_BYPASS_PD-8];
        p.headphone_amp = up & ~pd[`APMC_BIT_HEADPHONE_PD-8];
        p.stereo_dac    = up & ~pd[`APMC_BIT_DAC_PD-8];
        p.mono_driver   = up & ~pd[`APMC_BIT_MONO_PD-8];
        p.left_adc      = up & ~pd[`APMC_BIT_ADC_L_PD-8];
        p.right_adc     = up & ~pd[`APMC_BIT_ADC_R_PD-8];
        p.line_inputs   = p.mono_driver | p.left_adc | p.right_adc;
        p.mic_preamp    = p.mono_driver | p.left_adc | p.right_adc;
        p.left_mux_vol  = p.mono_driver | p.left_adc;
        p.right_mux_vol = p.right_adc;
        p.midrail_ref   = up & (p.bypass_path | p.headphone_amp | p.stereo_dac
                                | p.mono_driver | p.left_adc | p.right_adc
                                | (hold & ~pd[`APMC_BIT_MIDRAIL_PD-8]));
        return p;
    endfunction

    // ------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------
    assign wr_power     = reg_req.wr && (reg_req.addr == `APMC_OFS_POWER_MISC);
    assign pd_bits_next = reg_req.wdata[15:8];
    assign power_now    = power_decode(pd_bits_reg, midrail_hold_reg);
    assign power_next   = power_decode(pd_bits_next, midrail_hold_reg);

    // Power and miscellaneous control bits; the master bit is stored beside
    // the section bits so setting and clearing it never disturbs them.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pd_bits_reg     <= `APMC_RST_POWER_BITS;
            mic_bias_pd_reg <= `APMC_RST_MIC_BIAS_PD;
            xtal_en_reg     <= 1'h0;
            clkbuf_en_reg   <= 1'h0;
            sync_mon_pd_reg <= 1'h0;
            bass_reg        <= 1'h0;
            deemph_reg      <= 1'h0;
        end
        else if (wr_power)
        begin
            pd_bits_reg     <= pd_bits_next;
            mic_bias_pd_reg <= reg_req.wdata[`APMC_BIT_MIC_BIAS_PD];
            xtal_en_reg     <= reg_req.wdata[`APMC_BIT_XTAL_EN];
            clkbuf_en_reg   <= reg_req.wdata[`APMC_BIT_CLKBUF_EN];
            sync_mon_pd_reg <= reg_req.wdata[`APMC_BIT_SYNC_MON_PD];
            bass_reg        <= reg_req.wdata[`APMC_BIT_BASS];
            deemph_reg      <= reg_req.wdata[`APMC_BIT_DEEMPH];
        end
    end

    // Mono source and step rate bits.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mono_src_reg  <= `APMC_RST_MONO_SRC;
            step_rate_reg <= `APMC_RST_STEP_RATE;
        end
        else if (reg_req.wr && (reg_req.addr == `APMC_OFS_MONO_STEP))
        begin
            mono_src_reg  <= reg_req.wdata[`APMC_BIT_MONO_SRC];
            step_rate_reg <= reg_req.wdata[`APMC_BIT_STEP_RATE];
        end
    end

    // ------------------------------------------------------------------
    // Midrail reference hold.
    // ------------------------------------------------------------------

    // With the reference bit at 0 the reference stays up once powered; the
    // master power-down still takes it down.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            midrail_hold_reg <= 1'h0;
        else if (pd_bits_reg[`APMC_BIT_MASTER_PD-8] || pd_bits_reg[`APMC_BIT_MIDRAIL_PD-8])
            midrail_hold_reg <= 1'h0;
        else if (power_now.midrail_ref)
            midrail_hold_reg <= 1'h1;
    end

    // ------------------------------------------------------------------
    // Power sequencer.
    // ------------------------------------------------------------------

    // A write that changes any section state clears the done flag at once and
    // waits for settling; a cold reference start takes the long wait.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_state_reg <= APMC_SEQ_IDLE;
            seq_cnt_reg   <= '0;
            pwr_done_reg  <= 1'h1;
        end
        else if (wr_power && (power_next != power_now))
        begin
            seq_state_reg <= APMC_SEQ_SETTLE;
            pwr_done_reg  <= 1'h0;
            if (power_next.midrail_ref && !power_now.midrail_ref)
                seq_cnt_reg <= SEQ_W'(MIDRAIL_START_CYC);
            else
                seq_cnt_reg <= SEQ_W'(SECTION_SETTLE_CYC);
        end
        else
        begin
            case (seq_state_reg)
                APMC_SEQ_IDLE:
                begin
                    pwr_done_reg <= 1'h1;
                end
                APMC_SEQ_SETTLE:
                begin
                    if (seq_cnt_reg <= SEQ_W'(1))
                    begin
                        seq_state_reg <= APMC_SEQ_IDLE;
                        pwr_done_reg  <= 1'h1;
                        seq_cnt_reg   <= '0;
                    end
                    else
                        seq_cnt_reg <= seq_cnt_reg - SEQ_W'(1);
                end
                default:
                begin
                    seq_state_reg <= APMC_SEQ_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Soft-step timing and gain stepping.
    // ------------------------------------------------------------------

    // Step tick divider: one pulse per step period at the selected rate.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tick_cnt_reg <= '0;
        else if (tick)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 11'h001;
    end

    assign tick = step_rate_reg ? (tick_cnt_reg >= 11'(STEP_HALF_CYC - 1))
                                : (tick_cnt_reg >= 11'(STEP_NORMAL_CYC - 1));

    // A muted channel aims at the lowest gain while keeping its volume setting.
    assign target_left  = vol_left.mute  ? 7'h00 : vol_left.volume;
    assign target_right = vol_right.mute ? 7'h00 : vol_right.volume;

    // Gains move one step per tick toward their targets; zeroes go to the
    // filter only once a muted channel has reached the bottom.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gain_left      <= 7'h00;
            gain_right     <= 7'h00;
            dac_zero_left  <= 1'h1;
            dac_zero_right <= 1'h1;
        end
        else
        begin
            if (tick && (gain_left < target_left))
                gain_left <= gain_left + 7'h01;
            else if (tick && (gain_left > target_left))
                gain_left <= gain_left - 7'h01;
            if (tick && (gain_right < target_right))
                gain_right <= gain_right + 7'h01;
            else if (tick && (gain_right > target_right))
                gain_right <= gain_right - 7'h01;
            dac_zero_left  <= vol_left.mute && (gain_left == 7'h00);
            dac_zero_right <= vol_right.mute && (gain_right == 7'h00);
        end
    end

    // Done flag follows whether both gains sit at their targets.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            step_done_reg <= 1'h1;
        else
            step_done_reg <= (gain_left == target_left) && (gain_right == target_right);
    end

    // ------------------------------------------------------------------
    // Sync monitor.
    // ------------------------------------------------------------------

    // Two-stage synchroniser for the sync error level.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sync_meta_reg <= 2'h0;
        else
            sync_meta_reg <= {sync_meta_reg[0], i2s_sync_err};
    end

    // Sticky flag; a new loss in the read cycle wins over the clear.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sync_lost_reg <= 1'h0;
        else if (sync_meta_reg[1] && !sync_mon_pd_reg)
            sync_lost_reg <= 1'h1;
        else if (reg_req.rd && (reg_req.addr == `APMC_OFS_POWER_MISC))
            sync_lost_reg <= 1'h0;
    end

    // ------------------------------------------------------------------
    // Read path and outputs.
    // ------------------------------------------------------------------

    // Read data is registered one cycle after the request; other offsets read zero.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'h0;
        end
        else
        begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd)
            begin
                case (reg_req.addr)
                    `APMC_OFS_MONO_STEP:
                        reg_rdata <= {13'h0000, mono_src_reg, step_rate_reg, step_done_reg};
                    `APMC_OFS_POWER_MISC:
                        reg_rdata <= {pd_bits_reg, pwr_done_reg, mic_bias_pd_reg, xtal_en_reg,
                                      clkbuf_en_reg, sync_mon_pd_reg, sync_lost_reg,
                                      bass_reg, deemph_reg};
                    default:
                        reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Registered enables toward the analogue sections and clocking.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_on           <= '0;
            mono_source_select <= 1'h0;
            mic_bias_on        <= 1'h0;
            xtal_osc_on        <= 1'h0;
            clk_buf_on         <= 1'h0;
            sync_monitor_on    <= 1'h0;
            bass_enable        <= 1'h0;
            deemph_enable      <= 1'h0;
        end
        else
        begin
            power_on           <= power_now;
            mono_source_select <= mono_src_reg;
            mic_bias_on        <= ~mic_bias_pd_reg;
            xtal_osc_on        <= xtal_en_reg;
            clk_buf_on         <= clkbuf_en_reg;
            sync_monitor_on    <= ~sync_mon_pd_reg;
            bass_enable        <= bass_reg;
            deemph_enable      <= deemph_reg;
        end
    end

endmodule

// *** apmc_map.svh ***
`ifndef APMC_MAP_SVH
`define APMC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define APMC_OFS_MONO_STEP      6'h04
`define APMC_OFS_POWER_MISC     6'h05

// ----------------------------------------------------------------------
// Field positions of the mono and soft-step register.
// ----------------------------------------------------------------------
`define APMC_BIT_MONO_SRC       2
`define APMC_BIT_STEP_RATE      1
`define APMC_BIT_STEP_DONE      0

// ----------------------------------------------------------------------
// Field positions of the power and miscellaneous register.
// ----------------------------------------------------------------------
`define APMC_BIT_MASTER_PD      15
`define APMC_BIT_MIDRAIL_PD     14
`define APMC_BIT_BYPASS_PD      13
`define APMC_BIT_HEADPHONE_PD   12
`define APMC_BIT_MONO_PD        11
`define APMC_BIT_DAC_PD         10
`define APMC_BIT_ADC_L_PD       9
`define APMC_BIT_ADC_R_PD       8
`define APMC_BIT_PWR_DONE       7
`define APMC_BIT_MIC_BIAS_PD    6
`define APMC_BIT_XTAL_EN        5
`define APMC_BIT_CLKBUF_EN      4
`define APMC_BIT_SYNC_MON_PD    3
`define APMC_BIT_SYNC_LOST      2
`define APMC_BIT_BASS           1
`define APMC_BIT_DEEMPH         0

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define APMC_RST_POWER_BITS     8'hff
`define APMC_RST_MIC_BIAS_PD    1'h1
`define APMC_RST_MONO_SRC       1'h0
`define APMC_RST_STEP_RATE      1'h0

// ----------------------------------------------------------------------
// Timing, in nanoseconds, and the clock period.
// ----------------------------------------------------------------------
`define APMC_CLK_PERIOD_NS      25
`define APMC_STEP_NORMAL_NS     20000
`define APMC_STEP_HALF_NS       40000
`define APMC_MIDRAIL_START_NS   500000
`define APMC_STEP_NORMAL_CYC    (`APMC_STEP_NORMAL_NS / `APMC_CLK_PERIOD_NS)
`define APMC_STEP_HALF_CYC      (`APMC_STEP_HALF_NS / `APMC_CLK_PERIOD_NS)
`define APMC_MIDRAIL_START_CYC  ((`APMC_MIDRAIL_START_NS + `APMC_CLK_PERIOD_NS - 1) / `APMC_CLK_PERIOD_NS)

`endif

// *** apmc_pkg.sv ***
package apmc_pkg;

    // ------------------------------------------------------------------
    // Power-on state of each analogue section.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic midrail_ref;
        logic bypass_path;
        logic headphone_amp;
        logic mono_driver;
        logic stereo_dac;
        logic left_adc;
        logic right_adc;
        logic line_inputs;
        logic mic_preamp;
        logic left_mux_vol;
        logic right_mux_vol;
    } apmc_power_s;

    // ------------------------------------------------------------------
    // Register access from the serial control port decoder.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } apmc_reg_req_s;

    // ------------------------------------------------------------------
    // Volume request and mute of one DAC channel.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       mute;
        logic [6:0] volume;
    } apmc_vol_req_s;

    typedef enum logic [0:0] {
        APMC_SEQ_IDLE,
        APMC_SEQ_SETTLE
    } apmc_seq_e;

endpackage

// *** apmc_props.sv ***
module apmc_props
    import apmc_pkg::*;
(
    input wire logic          clk,                // System clock.
    input wire logic          arst_n,             // Reset, active low.
    input wire apmc_reg_req_s reg_req,            // Register request.
    input wire logic          reg_rvalid,         // Read valid pulse.
    input wire apmc_power_s   power_on,           // Section enables.
    input wire logic          mono_source_select, // Mono source.
    input wire logic          mic_bias_on,        // Bias enable.
    input wire logic          xtal_osc_on,        // Oscillator enable.
    input wire logic          sync_monitor_on,    // Monitor enable.
    input wire logic [6:0]    gain_left           // Stepped left gain.
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Decoded writes and the sequences built on them.
    // --------
    logic w4;
    logic w5;
    // A write is seen at the outputs two edges on, unless a second write follows at once.
    assign w4 = reg_req.wr && reg_req.addr == 6'h04;
    assign w5 = reg_req.wr && reg_req.addr == 6'h05;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_w4; w4 ##1 !w4; endsequence
    sequence s_w5; w5 ##1 !w5; endsequence
    sequence s_pwr(logic [7:0] v); w5 && reg_req.wdata[15:8] == v ##1 !w5; endsequence
    property p_rvalid; reg_req.rd |=> reg_rvalid; endproperty
    property p_mono; s_w4 |=> mono_source_select == $past(reg_req.wdata[2], 2); endproperty
    property p_xtal; s_w5 |=> xtal_osc_on == $past(reg_req.wdata[5], 2); endproperty
    property p_bias; s_w5 |=> mic_bias_on == !$past(reg_req.wdata[6], 2); endproperty
    property p_mon; s_w5 |=> sync_monitor_on == !$past(reg_req.wdata[3], 2); endproperty
    property p_master; s_w5 |=> !$past(reg_req.wdata[15], 2) || power_on == 11'h000; endproperty
    property p_ladc; s_pwr(8'h7d) |=> power_on[5:0] == 6'h2e; endproperty
    property p_step;
        $changed(gain_left) |-> (gain_left == $past(gain_left) + 7'h01 || gain_left == $past(gain_left) - 7'h01)
            ##1 $stable(gain_left) [*8];
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid missing");
    a_mono: assert property (p_mono) else $error("mono source wrong");
    a_xtal: assert property (p_xtal) else $error("oscillator enable wrong");
    a_bias: assert property (p_bias) else $error("mic bias wrong");
    a_mon: assert property (p_mon) else $error("sync monitor wrong");
    a_master: assert property (p_master) else $error("master power-down ignored");
    a_ladc: assert property (p_ladc) else $error("left ADC path wrong");
    a_step: assert property (p_step) else $error("gain step wrong");
endmodule
bind apmc_power_ctrl apmc_props i_props (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
    .power_on(power_on), .mono_source_select(mono_source_select), .mic_bias_on(mic_bias_on),
    .xtal_osc_on(xtal_osc_on), .sync_monitor_on(sync_monitor_on), .gain_left(gain_left));

// *** apmc_host.sv ***
module apmc_host
    import apmc_pkg::*;
(
    input wire logic        clk,        // System clock.
    output apmc_reg_req_s   reg_req,    // Request to the block.
    input wire logic [15:0] reg_rdata,  // Read data.
    input wire logic        reg_rvalid  // Read valid pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Host access.
    // --------
    initial reg_req = '0;
    // One access; idle lines show the inverse of the last value so stale data is never read.
    task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        reg_req <= '{wr, !wr, a, d};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
        q = 16'h0000;
        if (!wr)
        begin
            @(posedge clk);
            q = reg_rvalid ? reg_rdata : 16'hdead;
        end
    endtask
endmodule

// *** tb_top.sv ***
module tb_top
    import apmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Stimulus, model and checks.
    // --------
    logic          clk = 1'b0, arst_n = 1'b0, i2s_sync_err = 1'b0;
    apmc_vol_req_s vol_left = '0, vol_right = '0;
    apmc_reg_req_s reg_req;
    apmc_power_s   power_on;
    logic [15:0]   reg_rdata;
    logic [6:0]    gain_left, gain_right;
    logic reg_rvalid, mono_source_select, mic_bias_on, xtal_osc_on, clk_buf_on, sync_monitor_on, dac_zero_left;
    logic dac_zero_right;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    // Clock of 25 ns.
    always #12.5 clk = ~clk;
    apmc_power_ctrl #(.SECTION_SETTLE_CYC(4), .MIDRAIL_START_CYC(20)) i_dut (
        .clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .vol_left(vol_left), .vol_right(vol_right), .i2s_sync_err(i2s_sync_err), .power_on(power_on),
        .mono_source_select(mono_source_select), .mic_bias_on(mic_bias_on), .xtal_osc_on(xtal_osc_on),
        .clk_buf_on(clk_buf_on), .sync_monitor_on(sync_monitor_on), .bass_enable(), .deemph_enable(),
        .gain_left(gain_left), .gain_right(gain_right), .dac_zero_left(dac_zero_left),
        .dac_zero_right(dac_zero_right));
    apmc_host i_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] q;
        i_host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [5:0] a, input logic [15:0] e);
        logic [15:0] q;
        i_host.access(1'b0, a, 16'h0000, q);
        chk(n, e, q);
    endtask
    task automatic err_pulse;
        i2s_sync_err <= 1'b1;
        repeat (3) @(posedge clk);
        i2s_sync_err <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic until_gain(input logic [6:0] v, output int n);
        n = 0;
        while (gain_left !== v && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_reset;
        rd("reset power", 6'h05, 16'hffc0);
        rd("reset step", 6'h04, 16'h0001);
        chk("reset pins", 16'h0001, {power_on, mono_source_select, xtal_osc_on, clk_buf_on, mic_bias_on,
            sync_monitor_on});
        wr(6'h06, 16'hffff);
        rd("unmapped", 6'h06, 16'h0000);
        wr(6'h04, 16'hfffe);
        rd("step reg", 6'h04, 16'h0007);
        chk("mono pin", 16'h0001, {15'h0000, mono_source_select});
        wr(6'h04, 16'h0000);
        $display("test reset and map done");
    endtask
    task automatic t_misc;
        wr(6'h05, 16'hff33);
        repeat (2) @(posedge clk);
        chk("clock pins", 16'h0007, {13'h0000, xtal_osc_on, clk_buf_on, mic_bias_on});
        err_pulse();
        rd("lost set", 6'h05, 16'hffb7);
        rd("lost cleared", 6'h05, 16'hffb3);
        wr(6'h05, 16'hff7a);
        err_pulse();
        chk("monitor pin", 16'h0000, {15'h0000, sync_monitor_on});
        rd("monitor off", 6'h05, 16'hfffa);
        $display("test misc done");
    endtask
    task automatic t_power;
        logic [7:0]  b [8] = '{8'h7d, 8'h7e, 8'h4b, 8'hfd, 8'h3d, 8'h3f, 8'h7f, 8'h77};
        logic [10:0] e [8] = '{11'h42e, 11'h41d, 11'h740, 11'h000, 11'h42e, 11'h400, 11'h000, 11'h48e};
        logic [10:0] g;
        for (int i = 0; i < 8; i++)
        begin
            wr(6'h05, {b[i], 8'h40});
            rd("power busy", 6'h05, {b[i], 8'h40});
            g = power_on;
            chk("power map", {5'h00, e[i]}, {5'h00, g});
            repeat (40) @(posedge clk);
            rd("power done", 6'h05, {b[i], 8'hc0});
        end
        $display("test power done");
    endtask
    task automatic t_step;
        int n;
        vol_left <= '{1'b0, 7'h03};
        vol_right <= '{1'b0, 7'h01};
        repeat (3) @(posedge clk);
        rd("step busy", 6'h04, 16'h0000);
        until_gain(7'h01, n);
        until_gain(7'h02, n);
        chk("normal period", 16'h0320, n[15:0]);
        until_gain(7'h03, n);
        wr(6'h04, 16'h0002);
        vol_left <= '{1'b1, 7'h03};
        vol_right <= '{1'b1, 7'h01};
        until_gain(7'h02, n);
        until_gain(7'h01, n);
        chk("half period", 16'h0640, n[15:0]);
        chk("zero early", 16'h0000, {15'h0000, dac_zero_left});
        until_gain(7'h00, n);
        repeat (3) @(posedge clk);
        chk("zero sent", 16'h0001, {15'h0000, dac_zero_left});
        chk("right muted", 16'h0001, {8'h00, gain_right, dac_zero_right});
        rd("step over", 6'h04, 16'h0003);
        $display("test step done");
    endtask
    // Cycle ceiling against a hang.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_misc();
        t_power();
        t_step();
        conclude();
    end
endmodule
